//--- core/mdrop_map.svh
// Constants for the addressed multidrop command port.
// Assumes inclusion by the package and the design modules only.
`ifndef MDROP_MAP_SVH
`define MDROP_MAP_SVH
`define CH_STX 8'h02
`define CH_ETX 8'h03
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CMD_LEN 4'h6
`define CMD_PRINT 48'h4B5052494E54
`define CLK_HZ 20000000
`define BAUD_DEF 9600
`define DIV_DEF 16'h0823
`define FMT_8N 2'h0
`define FMT_7O 2'h1
`define FMT_7E 2'h2
`endif

//--- core/mdrop_pkg.sv
// Types shared by the multidrop command port files.
// Assumes the map header sits beside it in core/.
`include "mdrop_map.svh"
package mdrop_pkg;
	// Character format settings from configuration.
	typedef struct packed {
		logic [1:0] fmt;
		logic [15:0] div;
	} char_cfg_t;
	// Byte stream carrier with valid strobe.
	typedef struct packed {
		logic vld;
		logic [7:0] data;
	} byte_t;
	// Outgoing ticket line stream from the print source.
	typedef struct packed {
		logic vld;
		logic last;
		logic eol;
		logic [7:0] data;
	} line_t;
endpackage : mdrop_pkg

//--- core/uart_char.sv
// UART character engine: one receiver, one transmitter, shared format.
// Assumes rx_in is already synchronised by two flip-flops.
`timescale 1ns/1ps
module uart_char (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire mdrop_pkg::char_cfg_t cfg,
	input wire logic rx_in,
	output mdrop_pkg::byte_t rx_byte,
	output logic rx_err,
	input wire mdrop_pkg::byte_t tx_byte,
	output logic tx_ready,
	output logic tx_out,
	output logic tx_busy
);
	import mdrop_pkg::*;
	// Whole state of the engine in one struct.
	typedef struct packed {
		logic rx_on;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [9:0] rx_sh;
		logic tx_on;
		logic [15:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		byte_t rxo;
		logic err;
	} st_t;
	st_t st_r;
	st_t st_nxt;
	logic par;
	logic [3:0] nbits;

	// Parity over the seven data bits, odd or even per format.
	function automatic logic par7(input logic [6:0] d, input logic [1:0] f);
		par7 = (^d) ^ (f == `FMT_7O);
	endfunction : par7

	// Next-state logic for receiver and transmitter.
	always_comb begin
		st_nxt = st_r;
		st_nxt.rxo.vld = 1'b0;
		st_nxt.err = 1'b0;
		par = 1'b0;
		// Start, eight data or seven plus parity, stop: ten bits.
		nbits = 4'h9;
		if (!st_r.rx_on) begin
			// Start edge; sample mid-bit by loading half a period.
			if (!rx_in) begin
				st_nxt.rx_on = 1'b1;
				// A bit cell is div cycles, so this lands mid start bit.
				st_nxt.rx_cnt = {1'b0, cfg.div[15:1]} - 16'h0001;
				st_nxt.rx_bit = 4'h0;
			end
		end else if (st_r.rx_cnt != 16'h0000) begin
			st_nxt.rx_cnt = st_r.rx_cnt - 16'h0001;
		end else begin
			// Reload one short: the zero count is part of the cell.
			st_nxt.rx_cnt = cfg.div - 16'h0001;
			st_nxt.rx_sh = {rx_in, st_r.rx_sh[9:1]};
			st_nxt.rx_bit = st_r.rx_bit + 4'h1;
			if (st_r.rx_bit == 4'h0 && rx_in) begin
				// False start: glitch, go back to idle.
				st_nxt.rx_on = 1'b0;
			end else if (st_r.rx_bit == nbits) begin
				st_nxt.rx_on = 1'b0;
				st_nxt.rxo.vld = rx_in;
				if (cfg.fmt == `FMT_8N) begin
					st_nxt.rxo.data = st_r.rx_sh[9:2];
				end else begin
					// Seven data bits, parity checked.
					st_nxt.rxo.data = {1'b0, st_r.rx_sh[8:2]};
					if (par7(st_r.rx_sh[8:2], cfg.fmt) != st_r.rx_sh[9])
						st_nxt.rxo.vld = 1'b0;
				end
				st_nxt.err = ~st_nxt.rxo.vld;
			end
		end
		// Transmitter loads a frame when idle.
		if (!st_r.tx_on) begin
			if (tx_byte.vld) begin
				par = par7(tx_byte.data[6:0], cfg.fmt);
				st_nxt.tx_on = 1'b1;
				st_nxt.tx_cnt = cfg.div - 16'h0001;
				st_nxt.tx_bit = 4'h0;
				if (cfg.fmt == `FMT_8N)
					st_nxt.tx_sh = {1'b1, tx_byte.data, 1'b0};
				else
					st_nxt.tx_sh = {1'b1, par, tx_byte.data[6:0], 1'b0};
			end
		end else if (st_r.tx_cnt != 16'h0000) begin
			st_nxt.tx_cnt = st_r.tx_cnt - 16'h0001;
		end else begin
			st_nxt.tx_cnt = cfg.div - 16'h0001;
			st_nxt.tx_sh = {1'b1, st_r.tx_sh[9:1]};
			st_nxt.tx_bit = st_r.tx_bit + 4'h1;
			// Busy stays up through the whole stop bit.
			if (st_r.tx_bit == nbits)
				st_nxt.tx_on = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.tx_sh <= 10'h3FF;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rx_byte = st_r.rxo;
	assign rx_err = st_r.err;
	assign tx_ready = ~st_r.tx_on;
	assign tx_out = st_r.tx_on ? st_r.tx_sh[0] : 1'b1;
	assign tx_busy = st_r.tx_on;
endmodule : uart_char

//--- core/mdrop_port.sv
// Addressed multidrop command front end of the host serial port.
// Assumes a half-duplex transceiver: line_rx pin, line_tx and driver enable.
`timescale 1ns/1ps
`include "mdrop_map.svh"
// Overview of operation
// - Protocol enabled only by nonzero station address.
// - Frame is STX, address, command, CR.
// - Answer only when address equals own.
// - Stay silent unless addressed; never echo.
// - Print reply: STX, address, lines, ETX, CR.
// - One start, one stop, 7+parity or 8N.
// - End of line is CR LF or CR.
module mdrop_port #(
	parameter logic [15:0] BAUD_DIV = `DIV_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] station_addr,
	input wire logic [1:0] char_fmt,
	input wire logic eol_crlf,
	input wire logic line_rx,
	output logic line_tx,
	output logic line_tx_oe,
	output logic proto_on,
	output mdrop_pkg::byte_t cmd_out,
	output logic cmd_end,
	output logic print_req,
	input wire mdrop_pkg::line_t ticket_in,
	output logic ticket_ready
);
	import mdrop_pkg::*;
	// One-hot protocol states.
	typedef enum logic [7:0] {
		S_IDLE = 8'b0000_0001,
		S_ADDR = 8'b0000_0010,
		S_CMD = 8'b0000_0100,
		S_SKIP = 8'b0000_1000,
		S_HEAD = 8'b0001_0000,
		S_BODY = 8'b0010_0000,
		S_TAIL = 8'b0100_0000,
		S_DRAIN = 8'b1000_0000
	} state_t;
	// Whole state of the port.
	typedef struct packed {
		state_t st;
		logic [1:0] rx_sync;
		logic [2:0] step;
		logic [3:0] cidx;
		logic [47:0] cbuf;
		logic pend_lf;
		logic pend_last;
		logic tx_oe;
		logic on;
		byte_t cmd;
		logic cend;
		logic preq;
		byte_t txb;
		logic trdy;
	} port_t;
	port_t p_r;
	port_t p_nxt;
	byte_t rxb;
	logic rx_err;
	logic u_ready;
	logic u_out;
	logic u_busy;
	char_cfg_t cfg;
	logic [7:0] rch;

	// Character engine on the shared wire pair.
	assign cfg = '{fmt: char_fmt, div: BAUD_DIV};
	uart_char u_char (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.cfg(cfg),
		.rx_in(p_r.rx_sync[1]),
		.rx_byte(rxb),
		.rx_err(rx_err),
		.tx_byte(p_r.txb),
		.tx_ready(u_ready),
		.tx_out(u_out),
		.tx_busy(u_busy)
	);

	// Protocol sequencing; receive is ignored while we answer so our own
	// transmission is never taken for a new command.
	always_comb begin
		p_nxt = p_r;
		rch = rxb.data;
		p_nxt.rx_sync = {p_r.rx_sync[0], line_rx};
		p_nxt.cmd.vld = 1'b0;
		p_nxt.cend = 1'b0;
		p_nxt.preq = 1'b0;
		p_nxt.txb.vld = 1'b0;
		p_nxt.trdy = 1'b0;
		p_nxt.on = (station_addr != 8'h00);
		unique case (p_r.st)
			S_IDLE: begin
				p_nxt.tx_oe = 1'b0;
				if (rxb.vld && rch == `CH_STX && p_r.on)
					p_nxt.st = S_ADDR;
			end
			S_ADDR: begin
				if (rxb.vld) begin
					p_nxt.cidx = 4'h0;
					if (rch == `CH_STX)
						p_nxt.st = S_ADDR;
					else if (rch == station_addr)
						p_nxt.st = S_CMD;
					else
						p_nxt.st = S_SKIP;
				end
			end
			S_CMD: begin
				if (rxb.vld) begin
					if (rch == `CH_STX) begin
						p_nxt.st = S_ADDR;
					end else if (rch == `CH_CR) begin
						// Frame closes on CR alone.
						p_nxt.cend = 1'b1;
						p_nxt.st = S_IDLE;
						if (p_r.cidx == `CMD_LEN &&
							p_r.cbuf == `CMD_PRINT) begin
							p_nxt.preq = 1'b1;
							p_nxt.st = S_HEAD;
							p_nxt.step = 3'h0;
							p_nxt.tx_oe = 1'b1;
						end
					end else begin
						p_nxt.cmd = rxb;
						if (p_r.cidx != 4'hF)
							p_nxt.cidx = p_r.cidx + 4'h1;
						p_nxt.cbuf = {p_r.cbuf[39:0], rch};
					end
				end
			end
			S_SKIP: begin
				// Driver stays off; wait for the next frame start.
				p_nxt.tx_oe = 1'b0;
				if (rxb.vld && rch == `CH_STX)
					p_nxt.st = S_ADDR;
			end
			S_HEAD: begin
				// Reply header: STX then own address.
				if (u_ready && !p_r.txb.vld) begin
					p_nxt.txb.vld = 1'b1;
					p_nxt.txb.data = (p_r.step == 3'h0) ? `CH_STX :
						station_addr;
					p_nxt.step = p_r.step + 3'h1;
					if (p_r.step == 3'h1)
						p_nxt.st = S_BODY;
				end
			end
			S_BODY: begin
				if (u_ready && !p_r.txb.vld) begin
					if (p_r.pend_lf) begin
						p_nxt.txb = '{vld: 1'b1, data: `CH_LF};
						p_nxt.pend_lf = 1'b0;
						if (p_r.pend_last) begin
							p_nxt.st = S_TAIL;
							p_nxt.step = 3'h0;
						end
					end else if (ticket_in.vld) begin
						p_nxt.trdy = 1'b1;
						p_nxt.txb.vld = 1'b1;
						// Each line closed by CR, then LF if set.
						p_nxt.txb.data = ticket_in.eol ? `CH_CR :
							ticket_in.data;
						p_nxt.pend_lf = ticket_in.eol & eol_crlf;
						p_nxt.pend_last = ticket_in.last;
						if (ticket_in.last && !(ticket_in.eol & eol_crlf))
						begin
							p_nxt.st = S_TAIL;
							p_nxt.step = 3'h0;
						end
					end
				end
			end
			S_TAIL: begin
				// Trailer: ETX then CR.
				if (u_ready && !p_r.txb.vld) begin
					p_nxt.txb.vld = 1'b1;
					p_nxt.txb.data = (p_r.step == 3'h0) ? `CH_ETX : `CH_CR;
					p_nxt.step = p_r.step + 3'h1;
					if (p_r.step == 3'h1)
						p_nxt.st = S_DRAIN;
				end
			end
			S_DRAIN: begin
				// Release the driver only after the stop bit leaves.
				if (!u_busy && !p_r.txb.vld) begin
					p_nxt.tx_oe = 1'b0;
					p_nxt.st = S_IDLE;
				end
			end
			default: begin
				p_nxt.st = S_IDLE;
				p_nxt.tx_oe = 1'b0;
			end
		endcase
		// A bad character mid-frame abandons the frame.
		if (rx_err && (p_r.st == S_ADDR || p_r.st == S_CMD))
			p_nxt.st = S_SKIP;
		if (!p_r.on && !p_r.tx_oe)
			p_nxt.st = S_IDLE;
	end

	// State register and output flops.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			p_r <= '0;
			p_r.st <= S_IDLE;
			p_r.rx_sync <= 2'b11;
		end else begin
			p_r <= p_nxt;
		end
	end

	// Line data is held idle high when not driving.
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			line_tx <= 1'b1;
		else
			line_tx <= u_out | ~p_r.tx_oe;
	end

	assign line_tx_oe = p_r.tx_oe;
	assign proto_on = p_r.on;
	assign cmd_out = p_r.cmd;
	assign cmd_end = p_r.cend;
	assign print_req = p_r.preq;
	assign ticket_ready = p_r.trdy;
endmodule : mdrop_port

//--- testbench/mdrop_port_monitor.sv
// Checker for the multidrop command port; it sees top-level ports only.
// Assumes a bind to mdrop_port and a synchronous active-low reset.
`timescale 1ns/1ps
module mdrop_port_monitor (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] station_addr,
	input wire logic line_tx,
	input wire logic line_tx_oe,
	input wire logic proto_on,
	input wire mdrop_pkg::byte_t cmd_out,
	input wire logic cmd_end,
	input wire logic print_req,
	input wire logic ticket_ready
);
	import mdrop_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// The enable flag lags the address by one registered cycle.
	a_proto_follow: assert property ($past(rst_n) |->
		proto_on == ($past(station_addr) != 8'h00)) else $error("proto lag");
	a_idle_high: assert property (!line_tx_oe |-> line_tx)
		else $error("line not idle high");
	a_no_proto: assert property (!proto_on |->
		!line_tx_oe && !cmd_out.vld && !print_req) else $error("disabled");
	a_oe_cause: assert property ($rose(line_tx_oe) |->
		print_req || $past(print_req)) else $error("driver unasked");
	a_oe_follow: assert property (print_req |-> ##[0:1] line_tx_oe)
		else $error("no driver");
	a_start_bit: assert property ($rose(line_tx_oe) |-> ##[1:20] !line_tx)
		else $error("no start");
	a_stop_last: assert property ($fell(line_tx_oe) |-> $past(line_tx))
		else $error("early release");
	a_req_end: assert property (print_req |-> cmd_end || $past(cmd_end))
		else $error("req without end");
	c_print: cover property (print_req);
	c_ticket: cover property (ticket_ready);
	c_done: cover property ($fell(line_tx_oe));
endmodule : mdrop_port_monitor
bind mdrop_port mdrop_port_monitor mdrop_port_monitor_i (.sys_clk(sys_clk),
	.rst_n(rst_n), .station_addr(station_addr), .line_tx(line_tx),
	.line_tx_oe(line_tx_oe), .proto_on(proto_on), .cmd_out(cmd_out),
	.cmd_end(cmd_end), .print_req(print_req), .ticket_ready(ticket_ready));

//--- testbench/host_ctrl.sv
// Remote controller model: sends frames, decodes replies on the pair.
// Assumes the same bit period as the port's divider and no other station.
`timescale 1ns/1ps
module host_ctrl #(
	parameter int BIT = 4
) (
	input wire logic sys_clk,
	input wire logic [1:0] fmt,
	input wire logic line_tx,
	input wire logic line_tx_oe,
	output logic line_rx
);
	logic drv_en = 1'b0; // Own driver enable.
	logic drv_bit = 1'b1; // Own transmit level.
	logic [7:0] rx_q[$]; // Decoded reply characters.
	int perr = 0; // Parity and stop faults seen.
	// One shared pair; fail-safe bias holds an undriven pair at mark.
	assign line_rx = line_tx_oe ? line_tx : (drv_en ? drv_bit : 1'b1);
	// One bit cell, changed just after a rising edge.
	task automatic put_bit(input logic b);
		drv_bit = b;
		repeat (BIT) @(posedge sys_clk);
		#1;
	endtask : put_bit
	// Driver on, frame out, last stop bit done, then driver off.
	task automatic send_frame(input logic [7:0] f[$]);
		int nb;
		nb = (fmt == 2'h0) ? 8 : 7;
		@(posedge sys_clk);
		#1;
		drv_en = 1'b1;
		foreach (f[i]) begin
			put_bit(1'b0);
			for (int k = 0; k < nb; k++) put_bit(f[i][k]);
			if (fmt != 2'h0) put_bit(^f[i][6:0] ^ (fmt == 2'h1));
			put_bit(1'b1);
		end
		drv_en = 1'b0;
	endtask : send_frame
	// Listens only while the port drives, so its own echo is dropped.
	always begin : rx_side
		logic [7:0] d;
		int nb;
		@(posedge sys_clk iff (line_tx_oe && !line_tx));
		nb = (fmt == 2'h0) ? 8 : 7;
		d = 8'h00;
		repeat (BIT / 2) @(posedge sys_clk);
		for (int k = 0; k < nb; k++) begin
			repeat (BIT) @(posedge sys_clk);
			d[k] = line_tx;
		end
		if (fmt != 2'h0) begin
			repeat (BIT) @(posedge sys_clk);
			if (line_tx !== (^d[6:0] ^ (fmt == 2'h1))) perr++;
		end
		repeat (BIT) @(posedge sys_clk);
		if (line_tx !== 1'b1) perr++;
		rx_q.push_back(d);
	end
endmodule : host_ctrl

//--- testbench/addressed_multidrop_command_port_bench.sv
// Bench for the multidrop command port: print, restart, mismatch, zero.
// Assumes the partner model and the bound checker are compiled first.
`timescale 1ns/1ps
module addressed_multidrop_command_port_bench;
	import mdrop_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] station_addr = 8'h41;
	logic [1:0] char_fmt = 2'h0;
	logic eol_crlf = 1'b1;
	logic line_rx, line_tx, line_tx_oe, proto_on, cmd_end, print_req, rdy;
	byte_t cmd_out;
	line_t ticket_in = '0;
	int n_mismatch = 0;
	int checked = 0;
	int n_cmd, n_end, n_req;
	logic [7:0] cmd_last = 8'h00; // Last command character seen.
	always #25 sys_clk = ~sys_clk;
	mdrop_port #(.BAUD_DIV(16'h0004)) mdrop_port_i (.sys_clk(sys_clk),
		.rst_n(rst_n), .station_addr(station_addr), .char_fmt(char_fmt),
		.eol_crlf(eol_crlf), .line_rx(line_rx), .line_tx(line_tx),
		.line_tx_oe(line_tx_oe), .proto_on(proto_on), .cmd_out(cmd_out),
		.cmd_end(cmd_end), .print_req(print_req), .ticket_in(ticket_in),
		.ticket_ready(rdy));
	host_ctrl #(.BIT(4)) host_ctrl_i (.sys_clk(sys_clk), .fmt(char_fmt),
		.line_tx(line_tx), .line_tx_oe(line_tx_oe), .line_rx(line_rx));
	// Pulses are counted so each scenario judges them after its frame.
	always @(posedge sys_clk) begin
		if (cmd_out.vld === 1'b1) begin
			n_cmd++;
			cmd_last = cmd_out.data;
		end
		if (cmd_end === 1'b1) n_end++;
		if (print_req === 1'b1) n_req++;
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8
	task automatic give_verdict();
		$display("checked=%0d mismatches=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict
	// Configuration is static, so it only changes under reset.
	task automatic do_reset(input logic [7:0] a, input logic [1:0] f,
		input logic e);
		@(posedge sys_clk);
		#1;
		rst_n = 1'b0;
		station_addr = a;
		char_fmt = f;
		eol_crlf = e;
		repeat (6) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		n_cmd = 0;
		n_end = 0;
		n_req = 0;
		host_ctrl_i.rx_q.delete();
	endtask : do_reset
	// Print command to address a; pre puts an aborted frame first.
	// Only demand replies are driven, never a streaming setup.
	task automatic go(input logic [7:0] a, input logic pre);
		logic [7:0] f[$];
		f = {8'h02, a, 8'h4B, 8'h50, 8'h52, 8'h49, 8'h4E, 8'h54, 8'h0D};
		if (pre) f = {8'h02, a, 8'h5A, f};
		host_ctrl_i.send_frame(f);
	endtask : go
	// Two ticket lines, each item held until the port takes it.
	task automatic feed();
		line_t it[4];
		int w;
		it = '{{3'b100, 8'h58}, {3'b101, 8'h00}, {3'b100, 8'h59},
			{3'b111, 8'h00}};
		#1;
		foreach (it[i]) begin
			ticket_in = it[i];
			w = 0;
			do begin
				@(posedge sys_clk);
				w++;
			end while (rdy !== 1'b1 && w < 4000);
			if (w >= 4000) begin
				n_mismatch++;
				give_verdict();
			end
			#1;
		end
		ticket_in = '0;
	endtask : feed
	// Waits for the driver to drop, then a little settling time.
	task automatic wait_quiet();
		int w;
		w = 0;
		do begin
			@(posedge sys_clk);
			w++;
		end while (line_tx_oe !== 1'b0 && w < 4000);
		if (w >= 4000) begin
			n_mismatch++;
			give_verdict();
		end
		repeat (20) @(posedge sys_clk);
	endtask : wait_quiet
	task automatic reply(input logic [7:0] e[$]);
		chk8(8'(host_ctrl_i.rx_q.size()), 8'(e.size()));
		foreach (e[i]) if (i < host_ctrl_i.rx_q.size())
			chk8(host_ctrl_i.rx_q[i], e[i]);
		chk8(8'(host_ctrl_i.perr), 8'h00);
	endtask : reply
	task automatic t_print();
		do_reset(8'h41, 2'h0, 1'b1);
		chk8(8'(proto_on), 8'h01);
		fork
			go(8'h41, 1'b0);
			feed();
		join
		wait_quiet();
		reply({8'h02, 8'h41, 8'h58, 8'h0D, 8'h0A, 8'h59, 8'h0D, 8'h0A,
			8'h03, 8'h0D});
		chk8(8'(n_cmd), 8'h06);
		chk8(cmd_last, 8'h54);
		chk8(8'(n_end + n_req), 8'h02);
		$display("test print done");
	endtask : t_print
	task automatic t_restart();
		do_reset(8'h41, 2'h2, 1'b0);
		fork
			go(8'h41, 1'b1);
			feed();
		join
		wait_quiet();
		reply({8'h02, 8'h41, 8'h58, 8'h0D, 8'h59, 8'h0D, 8'h03,
			8'h0D});
		chk8(8'(n_req), 8'h01);
		$display("test restart done");
	endtask : t_restart
	task automatic t_mismatch();
		do_reset(8'h41, 2'h1, 1'b1);
		go(8'h42, 1'b0);
		repeat (60) @(posedge sys_clk);
		chk8(8'(n_cmd + n_req), 8'h00);
		chk8(8'(host_ctrl_i.rx_q.size()), 8'h00);
		fork
			go(8'h41, 1'b0);
			feed();
		join
		wait_quiet();
		reply({8'h02, 8'h41, 8'h58, 8'h0D, 8'h0A, 8'h59, 8'h0D, 8'h0A,
			8'h03, 8'h0D});
		$display("test mismatch done");
	endtask : t_mismatch
	task automatic t_zero();
		do_reset(8'h00, 2'h0, 1'b1);
		chk8(8'(proto_on), 8'h00);
		go(8'h00, 1'b0);
		repeat (60) @(posedge sys_clk);
		chk8(8'(n_cmd + n_req), 8'h00);
		chk8(8'(host_ctrl_i.rx_q.size()), 8'h00);
		$display("test zero done");
	endtask : t_zero
	initial begin
		t_print();
		t_restart();
		t_mismatch();
		t_zero();
		give_verdict();
	end
endmodule : addressed_multidrop_command_port_bench
